// file: src/wdt_top.sv
// watchdog timer with grace window, chip reset and power-down wake-up
`timescale 1ns/10ps

module wdt_top
  import wdt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wdog_clock_in,
  input wire logic power_down_in,
  input wire wdt_bus_t bus_in,
  output logic [WDT_DATA_W-1:0] rdata_out,
  output logic irq_out,
  output logic chip_reset_out,
  output logic wake_out
);

  // wdog_clock synchroniser; first stage feeds only the second
  logic wclk_s1;
  logic wclk_s2;
  logic wclk_s3;

  logic [WDT_CNT_W-1:0] cnt;
  logic wdog_enable;
  logic counter_clear;
  logic reset_enable;
  logic timeout_irq_enable;
  logic [2:0] interval_select;
  logic timeout_flag;
  logic reset_occurred_flag;
  logic wake_enable;
  logic [WDT_EV_W-1:0] stat;
  logic [WDT_EV_W-1:0] mask;
  logic grace_on;
  logic [9:0] grace_cnt;
  logic rst_on;
  logic [5:0] rst_cnt;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wclk_s1 <= 1'b0;
      wclk_s2 <= 1'b0;
      wclk_s3 <= 1'b0;
    end else begin
      wclk_s1 <= wdog_clock_in;
      wclk_s2 <= wclk_s1;
      wclk_s3 <= wclk_s2;
    end
  end

  // one core cycle per rising wdog_clock edge
  wire tick = wclk_s2 & ~wclk_s3;

  // bus decode
  wire wr_ctrl = bus_in.wr && (bus_in.addr == WDT_OFS_CTRL);
  wire wr_wake = bus_in.wr && (bus_in.addr == WDT_OFS_WAKE);
  wire wr_stat = bus_in.wr && (bus_in.addr == WDT_OFS_STAT);
  wire wr_mask = bus_in.wr && (bus_in.addr == WDT_OFS_MASK);
  wire [WDT_DATA_W-1:0] wd = bus_in.wdata;

  // interval compare: top is span-1, so 2^18 wraps to all ones
  wire [18:0] sel_span = WDT_SPAN_MIN << {interval_select, 1'b0};
  wire [WDT_CNT_W-1:0] sel_top = sel_span[WDT_CNT_W-1:0] - 18'h1;

  // clear is honoured only on a wdog tick so it lands in that time base
  wire do_clear = tick & counter_clear;
  wire count_on = tick & wdog_enable & ~do_clear & ~rst_on;
  wire timeout_ev = count_on && (cnt == sel_top);
  wire grace_end = tick && grace_on && !do_clear && (grace_cnt == WDT_GRACE_LAST);
  wire rst_start = grace_end & reset_enable;
  wire rst_end = tick && rst_on && (rst_cnt == WDT_RST_LAST);
  wire wake_ev = timeout_ev & power_down_in & wake_enable;

  wire [WDT_EV_W-1:0] ev_vec = {rst_start, wake_ev, timeout_ev};
  wire [WDT_EV_W-1:0] stat_clr = wr_stat ? wd[WDT_EV_W-1:0] : 3'h0;
  wire [WDT_EV_W-1:0] next_stat = (stat & ~stat_clr) | ev_vec;

  // time-out only reaches the interrupt line when its enable is set
  wire [WDT_EV_W-1:0] irq_gate = {2'b11, timeout_irq_enable};
  wire next_irq = |(next_stat & mask & irq_gate);

  // counter
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else if (do_clear || rst_end) begin
      cnt <= '0;
    end else if (count_on) begin
      cnt <= cnt + 18'h1;
    end
  end

  // grace window; a time-out inside a running window does not restart it
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      grace_on <= 1'b0;
      grace_cnt <= '0;
    end else if (do_clear || grace_end) begin
      grace_on <= 1'b0;
      grace_cnt <= '0;
    end else if (timeout_ev && !grace_on) begin
      grace_on <= 1'b1;
      grace_cnt <= '0;
    end else if (tick && grace_on) begin
      grace_cnt <= grace_cnt + 10'h1;
    end
  end

  // chip reset length
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_on <= 1'b0;
      rst_cnt <= '0;
    end else if (rst_start) begin
      rst_on <= 1'b1;
      rst_cnt <= '0;
    end else if (rst_end) begin
      rst_on <= 1'b0;
    end else if (tick && rst_on) begin
      rst_cnt <= rst_cnt + 6'h1;
    end
  end

  // control bits
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wdog_enable <= 1'b0;
      reset_enable <= 1'b0;
      timeout_irq_enable <= 1'b0;
      interval_select <= WDT_SEL_RST;
      wake_enable <= 1'b0;
      mask <= WDT_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        wdog_enable <= wd[WDT_B_EN];
        reset_enable <= wd[WDT_B_RSTEN];
        timeout_irq_enable <= wd[WDT_B_TOIE];
        interval_select <= wd[WDT_B_SEL_HI:WDT_B_SEL_LO];
      end
      if (wr_wake) begin
        wake_enable <= wd[WDT_B_WAKEEN];
      end
      if (wr_mask) begin
        mask <= wd[WDT_EV_W-1:0];
      end
    end
  end

  // clear request: a new write wins over the self-clear
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      counter_clear <= 1'b0;
    end else if (wr_ctrl && wd[WDT_B_CLR]) begin
      counter_clear <= 1'b1;
    end else if (do_clear) begin
      counter_clear <= 1'b0;
    end
  end

  // sticky flags, write one to clear, event wins over clear
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timeout_flag <= 1'b0;
      reset_occurred_flag <= 1'b0;
      stat <= '0;
    end else begin
      timeout_flag <= timeout_ev | (timeout_flag & ~(wr_ctrl & wd[WDT_B_TOFLG]));
      // rst_in is power-on only, so chip_reset_out never clears this
      reset_occurred_flag <= rst_start
        | (reset_occurred_flag & ~(wr_ctrl & wd[WDT_B_RSTFLG]));
      stat <= next_stat;
    end
  end

  // read mux
  logic [WDT_DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (bus_in.addr)
      WDT_OFS_CTRL: begin
        rd_mux[WDT_B_CLR] = counter_clear;
        rd_mux[WDT_B_RSTEN] = reset_enable;
        rd_mux[WDT_B_RSTFLG] = reset_occurred_flag;
        rd_mux[WDT_B_TOFLG] = timeout_flag;
        rd_mux[WDT_B_TOIE] = timeout_irq_enable;
        rd_mux[WDT_B_EN] = wdog_enable;
        rd_mux[WDT_B_SEL_HI:WDT_B_SEL_LO] = interval_select;
      end
      WDT_OFS_WAKE: rd_mux[WDT_B_WAKEEN] = wake_enable;
      WDT_OFS_STAT: rd_mux[WDT_EV_W-1:0] = stat;
      WDT_OFS_MASK: rd_mux[WDT_EV_W-1:0] = mask;
      WDT_OFS_CNT: rd_mux[WDT_CNT_W-1:0] = cnt;
      default: rd_mux = '0;
    endcase
  end

  // outputs all registered
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
      irq_out <= 1'b0;
      chip_reset_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      rdata_out <= bus_in.rd ? rd_mux : '0;
      irq_out <= next_irq;
      chip_reset_out <= (rst_on & ~rst_end) | rst_start;
      wake_out <= wake_ev;
    end
  end

endmodule

// file: src/wdt_pkg.sv
// package: watchdog register map, field positions, counts and bus carrier
package wdt_pkg;

  localparam int WDT_ADDR_W = 8;
  localparam int WDT_DATA_W = 32;
  localparam int WDT_CNT_W = 18;

  // register byte offsets
  localparam logic [7:0] WDT_OFS_CTRL = 8'h00;
  localparam logic [7:0] WDT_OFS_WAKE = 8'h04;
  localparam logic [7:0] WDT_OFS_STAT = 8'h08;
  localparam logic [7:0] WDT_OFS_MASK = 8'h0c;
  localparam logic [7:0] WDT_OFS_CNT = 8'h10;

  // wdog_control fields
  localparam int WDT_B_CLR = 0;
  localparam int WDT_B_RSTEN = 1;
  localparam int WDT_B_RSTFLG = 2;
  localparam int WDT_B_TOFLG = 3;
  localparam int WDT_B_TOIE = 6;
  localparam int WDT_B_EN = 7;
  localparam int WDT_B_SEL_LO = 8;
  localparam int WDT_B_SEL_HI = 10;

  // wdog_wake_ctrl field
  localparam int WDT_B_WAKEEN = 4;

  // interrupt status / mask bits
  localparam int WDT_EV_W = 3;
  localparam int WDT_EV_TO = 0;
  localparam int WDT_EV_WAKE = 1;
  localparam int WDT_EV_RST = 2;

  // counts in wdog_clock periods
  localparam int WDT_GRACE_PERIODS = 1024;
  localparam int WDT_RST_PERIODS = 63;
  localparam logic [9:0] WDT_GRACE_LAST = 10'(WDT_GRACE_PERIODS - 1);
  localparam logic [5:0] WDT_RST_LAST = 6'(WDT_RST_PERIODS - 1);
  localparam logic [18:0] WDT_SPAN_MIN = 19'h00010;

  // reset values
  localparam logic [2:0] WDT_SEL_RST = 3'h0;
  localparam logic [WDT_EV_W-1:0] WDT_MASK_RST = 3'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [WDT_ADDR_W-1:0] addr;
    logic [WDT_DATA_W-1:0] wdata;
  } wdt_bus_t;

endpackage

// file: tb/wdt_monitor.sv
// checker: port-level properties of the watchdog
`timescale 1ns/10ps
module wdt_chk
  import wdt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wdog_clock_in,
  input wire logic power_down_in,
  input wire wdt_bus_t bus_in,
  input wire logic [WDT_DATA_W-1:0] rdata_out,
  input wire logic irq_out,
  input wire logic chip_reset_out,
  input wire logic wake_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd(logic [7:0] a);
    bus_in.rd && bus_in.addr == a;
  endsequence
  sequence s_wsel;
    bus_in.wr && bus_in.addr == WDT_OFS_CTRL ##2 s_rd(WDT_OFS_CTRL);
  endsequence
  property p_idle; !$past(bus_in.rd) |-> rdata_out == '0; endproperty
  property p_unmap; s_rd(8'h14) |=> rdata_out == '0; endproperty
  property p_maskw; s_rd(WDT_OFS_MASK) |=> rdata_out[31:WDT_EV_W] == '0; endproperty
  property p_cntw; s_rd(WDT_OFS_CNT) |=> rdata_out[31:WDT_CNT_W] == '0; endproperty
  property p_sel; s_wsel |=> rdata_out[10:8] == $past(bus_in.wdata[10:8], 3); endproperty
  property p_irqm;
    bus_in.wr && bus_in.addr == WDT_OFS_MASK && bus_in.wdata[2:0] == 3'h0 |-> ##2 !irq_out;
  endproperty
  property p_wake1; wake_out |=> !wake_out; endproperty
  property p_wakepd; wake_out |-> $past(power_down_in) || $past(power_down_in, 2); endproperty
  property p_rsthold; $rose(chip_reset_out) |-> chip_reset_out [*8]; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_maskw: assert property (p_maskw) else $error("mask width");
  a_cntw: assert property (p_cntw) else $error("count width");
  a_sel: assert property (p_sel) else $error("select readback");
  a_irqm: assert property (p_irqm) else $error("masked irq");
  a_wake1: assert property (p_wake1) else $error("wake width");
  a_wakepd: assert property (p_wakepd) else $error("wake while up");
  a_rsthold: assert property (p_rsthold) else $error("reset short");
endmodule

bind wdt_top wdt_chk u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .wdog_clock_in(wdog_clock_in), .power_down_in(power_down_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .irq_out(irq_out), .chip_reset_out(chip_reset_out),
  .wake_out(wake_out));

// file: tb/watchdog_reset_wakeup_timer_tb.sv
// testbench: register-level scenarios for the watchdog
`timescale 1ns/10ps
module watchdog_reset_wakeup_timer_tb
  import wdt_pkg::*;
;
  logic clk = 0, rst = 1, wck = 0, pd = 0;
  // wake pulses are counted, so only this process drives the count
  logic [31:0] wake_n = 0;
  wdt_bus_t bus = '0;
  logic [WDT_DATA_W-1:0] rdata;
  logic irq, crst, wake;
  int err_count = 0, n_checks = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (wake) wake_n <= wake_n + 1;
  wdt_top dut (.core_clk_in(clk), .rst_in(rst), .wdog_clock_in(wck),
    .power_down_in(pd), .bus_in(bus), .rdata_out(rdata), .irq_out(irq),
    .chip_reset_out(crst), .wake_out(wake));
  task chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.wr <= 1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    bus.rd <= 1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 0;
    #1 chk($sformatf("reg %h", a), rdata & m, e);
  endtask
  // one slow-clock period spans seven core cycles
  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      wck <= 1;
      repeat (3) @(posedge clk);
      wck <= 0;
      repeat (3) @(posedge clk);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rd(WDT_OFS_CTRL, '1, 0);
    rd(WDT_OFS_MASK, '1, 0);
    wr(8'h14, '1);
    rd(8'h14, '1, 0);
    for (int i = 0; i < 8; i++) begin
      wr(WDT_OFS_CTRL, 32'(i) << 8);
      rd(WDT_OFS_CTRL, 32'h700, 32'(i) << 8);
    end
    tick(20);
    rd(WDT_OFS_CNT, '1, 0);
    wr(WDT_OFS_MASK, 1);
    wr(WDT_OFS_CTRL, 32'hc0);
    tick(15);
    rd(WDT_OFS_CNT, '1, 15);
    rd(WDT_OFS_CTRL, 8, 0);
    tick(1);
    rd(WDT_OFS_CTRL, 8, 8);
    chk("irq", irq, 1);
    chk("woke", wake_n, 0);
    wr(WDT_OFS_MASK, 0);
    rd(WDT_OFS_MASK, '1, 0);
    chk("irq", irq, 0);
    wr(WDT_OFS_MASK, 1);
    wr(WDT_OFS_STAT, 1);
    rd(WDT_OFS_STAT, 1, 0);
    chk("irq", irq, 0);
    wr(WDT_OFS_CTRL, 32'hc1);
    rd(WDT_OFS_CNT, '1, 16);
    tick(1);
    rd(WDT_OFS_CNT, '1, 0);
    rd(WDT_OFS_CTRL, 1, 0);
    wr(WDT_OFS_CTRL, 32'h82);
    tick(1016);
    wr(WDT_OFS_CTRL, 32'h83);
    tick(1);
    chk("chip reset", crst, 0);
    tick(1039);
    chk("chip reset", crst, 0);
    tick(1);
    chk("chip reset", crst, 1);
    rd(WDT_OFS_STAT, 4, 4);
    tick(62);
    chk("chip reset", crst, 1);
    tick(1);
    chk("chip reset", crst, 0);
    rd(WDT_OFS_CTRL, 4, 4);
    wr(WDT_OFS_CTRL, 32'h81);
    wr(WDT_OFS_WAKE, 32'h10);
    tick(1);
    pd <= 1;
    tick(16);
    chk("woke", wake_n, 1);
    rd(WDT_OFS_STAT, 2, 2);
    pd <= 0;
    wr(WDT_OFS_CTRL, 32'h83);
    tick(1);
    rd(WDT_OFS_CNT, '1, 0);
    chk("chip reset", crst, 0);
    close_out;
  end
endmodule
